/* File: rtl/tsod_defines.svh */
// Object indices, field positions, signatures and reset values.
// Assumes inclusion by bare name from the package and the top module.
`ifndef TSOD_DEFINES_SVH
`define TSOD_DEFINES_SVH

`define TSOD_IDX_DEV_TYPE 16'h1000
`define TSOD_IDX_FAULT_FLAGS 16'h1001
`define TSOD_IDX_FAULT_HIST 16'h1003
`define TSOD_IDX_SYNC_ID 16'h1005
`define TSOD_IDX_GUARD 16'h100c
`define TSOD_IDX_LIFE 16'h100d
`define TSOD_IDX_STORE 16'h1010
`define TSOD_IDX_RESTORE 16'h1011
`define TSOD_IDX_POS_LONG 16'h6010
`define TSOD_IDX_OP_LONG 16'h6011
`define TSOD_IDX_OFS_LONG 16'h6012
`define TSOD_IDX_POS_TRANS 16'h6020
`define TSOD_IDX_OP_TRANS 16'h6021
`define TSOD_IDX_OFS_TRANS 16'h6022

`define TSOD_SUB_ZERO 8'h00
`define TSOD_SUB_FIRST 8'h01
`define TSOD_SUB_ALL 8'h01
`define TSOD_SUB_COMM 8'h02
`define TSOD_SUB_APP 8'h03
`define TSOD_SUB_MFR 8'h04
`define TSOD_NV_SUB_COUNT 32'h0000_0004
`define TSOD_NV_SUB_READ 32'h0000_0001

`define TSOD_SIG_SAVE 32'h6576_6173
`define TSOD_SIG_LOAD 32'h6461_6f6c

`define TSOD_OP_INV_BIT 0
`define TSOD_OP_SCALE_BIT 1
`define TSOD_FAULT_GENERIC_BIT 0
`define TSOD_INV_BASE 17'h1_0000
`define TSOD_SYNC_ID_RST 32'h0000_0080
`define TSOD_SYNC_ID_W 11

`define TSOD_GRP_COMM 3'b001
`define TSOD_GRP_APP 3'b010
`define TSOD_GRP_MFR 3'b100
`define TSOD_GRP_ALL 3'b111
`define TSOD_GRP_NONE 3'b000

`define TSOD_ABT_NO_OBJ 32'h0602_0000
`define TSOD_ABT_NO_SUB 32'h0609_0011
`define TSOD_ABT_RO 32'h0601_0002
`define TSOD_ABT_WO 32'h0601_0001
`define TSOD_ABT_SIG 32'h0800_0020
`define TSOD_ABT_VALUE 32'h0609_0030

`endif

/* File: rtl/tsod_pkg.sv */
// Carrier types of the object dictionary block.
// Assumes the defines header is on the include path.
`include "tsod_defines.svh"

package tsod_pkg;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] data;
    } tsod_req_type;

    typedef struct packed {
        logic valid;
        logic abort;
        logic [31:0] data;
    } tsod_rsp_type;

    typedef struct packed {
        logic [15:0] info;
        logic [15:0] code;
    } tsod_fault_type;

    typedef struct packed {
        logic store;
        logic restore;
        logic [2:0] groups;
        logic preset;
        logic app_first;
        logic keep_link;
    } tsod_nv_type;

endpackage

/* File: rtl/tsod_top.sv */
// Object dictionary of the inclination sensor: transform, fault log,
// sync reply, guarding figures and signature-protected store/restore.
// Assumes the CAN stack delivers one dictionary request per cycle at most.
`timescale 1ns/1ps
`include "tsod_defines.svh"

module tsod_top
    import tsod_pkg::*;
#(
    parameter int LOG_DEPTH = 8,
    // Arbitrary values
    parameter logic [15:0] DEV_PROFILE = 16'h0123,
    parameter logic [15:0] DEV_EXTRA = 16'h0004
) (
    input wire logic CLK,
    input wire logic RST_N,
    input tsod_req_type REQ,
    output tsod_rsp_type RSP,
    input wire logic [15:0] POS_LONG,
    input wire logic [15:0] POS_TRANS,
    input wire logic FAULT_ACTIVE,
    input wire logic FAULT_EVENT,
    input tsod_fault_type FAULT_ENTRY,
    input wire logic NMT_OPERATIONAL,
    input wire logic SYNC_VALID,
    input wire logic [10:0] SYNC_ID,
    output logic PDO_SEND,
    output logic [31:0] PDO_DATA,
    output logic [15:0] TILT_LONGITUDINAL_16BIT,
    output logic [15:0] TILT_TRANSVERSE_16BIT,
    output logic [31:0] TILT_LONGITUDINAL_32BIT,
    output logic [31:0] TILT_TRANSVERSE_32BIT,
    output logic [23:0] LIFE_TIME_MS,
    output tsod_nv_type NV_CMD,
    output logic [2:0] NV_RESTORE_PENDING
);

    // Depth is counted in an 8-bit sub-index
    if (LOG_DEPTH < 1 || LOG_DEPTH > 254) begin
        $error("LOG_DEPTH out of range");
    end

    localparam logic [7:0] LOG_MAX = 8'(LOG_DEPTH);
    localparam int IDX_W = (LOG_DEPTH > 1) ? $clog2(LOG_DEPTH) : 1;

    logic [7:0] op_long_ff, op_trans_ff;
    logic [15:0] ofs_long_ff, ofs_trans_ff;
    logic [15:0] tilt_long_ff, tilt_trans_ff;
    logic [31:0] sync_id_ff;
    logic [15:0] guard_ff;
    logic [7:0] life_ff;
    logic [23:0] life_ms_ff;
    logic [7:0] fault_flags_ff;
    logic [31:0] log_ff [LOG_DEPTH];
    logic [7:0] log_cnt_ff;
    logic pdo_send_ff;
    logic [31:0] pdo_data_ff;
    tsod_rsp_type rsp_ff;
    tsod_nv_type nv_ff;
    logic [2:0] restore_pend_ff;

    // Decode results
    logic [31:0] rd_data;
    logic [31:0] abort_code;
    logic req_abort;
    logic wr_op_long, wr_op_trans, wr_ofs_long, wr_ofs_trans;
    logic wr_sync, wr_guard, wr_life, wr_log_clr;
    logic nv_save, nv_load;
    logic [2:0] nv_groups;

    function automatic logic [15:0] tilt_xform(input logic [15:0] pos,
                                               input logic [7:0] op,
                                               input logic [15:0] ofs);
        logic [15:0] v;
        v = pos;
        if (op[`TSOD_OP_INV_BIT]) begin
            v = 16'(`TSOD_INV_BASE - {1'b0, pos});
        end
        if (op[`TSOD_OP_SCALE_BIT]) begin
            v = 16'(v + ofs);
        end
        return v;
    endfunction

    function automatic logic [2:0] sub_to_groups(input logic [7:0] sub);
        logic [2:0] g;
        g = `TSOD_GRP_NONE;
        if (sub == `TSOD_SUB_ALL) begin
            g = `TSOD_GRP_ALL;
        end else if (sub == `TSOD_SUB_COMM) begin
            g = `TSOD_GRP_COMM;
        end else if (sub == `TSOD_SUB_APP) begin
            g = `TSOD_GRP_APP;
        end else if (sub == `TSOD_SUB_MFR) begin
            g = `TSOD_GRP_MFR;
        end
        return g;
    endfunction

    always_comb begin
        rd_data = 32'h0000_0000;
        abort_code = 32'h0000_0000;
        wr_op_long = 1'b0;
        wr_op_trans = 1'b0;
        wr_ofs_long = 1'b0;
        wr_ofs_trans = 1'b0;
        wr_sync = 1'b0;
        wr_guard = 1'b0;
        wr_life = 1'b0;
        wr_log_clr = 1'b0;
        nv_save = 1'b0;
        nv_load = 1'b0;
        nv_groups = sub_to_groups(REQ.sub);
        if (REQ.index == `TSOD_IDX_DEV_TYPE) begin
            rd_data = {DEV_EXTRA, DEV_PROFILE};
            if (REQ.write) begin
                abort_code = `TSOD_ABT_RO;
            end
        end else if (REQ.index == `TSOD_IDX_FAULT_FLAGS) begin
            rd_data = {24'h00_0000, fault_flags_ff};
            if (REQ.write) begin
                abort_code = `TSOD_ABT_RO;
            end
        end else if (REQ.index == `TSOD_IDX_FAULT_HIST) begin
            if (REQ.sub == `TSOD_SUB_ZERO) begin
                rd_data = {24'h00_0000, log_cnt_ff};
                if (REQ.write && REQ.data != 32'h0000_0000) begin
                    abort_code = `TSOD_ABT_VALUE;
                end else if (REQ.write) begin
                    wr_log_clr = 1'b1;
                end
            end else if (REQ.sub <= log_cnt_ff) begin
                rd_data = log_ff[IDX_W'(REQ.sub - `TSOD_SUB_FIRST)];
                if (REQ.write) begin
                    abort_code = `TSOD_ABT_RO;
                end
            end else begin
                abort_code = `TSOD_ABT_NO_SUB;
            end
        end else if (REQ.index == `TSOD_IDX_SYNC_ID) begin
            rd_data = sync_id_ff;
            wr_sync = REQ.write;
        end else if (REQ.index == `TSOD_IDX_GUARD) begin
            rd_data = {16'h0000, guard_ff};
            wr_guard = REQ.write;
        end else if (REQ.index == `TSOD_IDX_LIFE) begin
            rd_data = {24'h00_0000, life_ff};
            wr_life = REQ.write;
        end else if (REQ.index == `TSOD_IDX_STORE ||
                     REQ.index == `TSOD_IDX_RESTORE) begin
            if (REQ.sub == `TSOD_SUB_ZERO) begin
                rd_data = `TSOD_NV_SUB_COUNT;
                if (REQ.write) begin
                    abort_code = `TSOD_ABT_RO;
                end
            end else if (nv_groups == `TSOD_GRP_NONE) begin
                abort_code = `TSOD_ABT_NO_SUB;
            end else if (!REQ.write) begin
                rd_data = `TSOD_NV_SUB_READ;
            end else if (REQ.index == `TSOD_IDX_STORE) begin
                if (REQ.data == `TSOD_SIG_SAVE) begin
                    nv_save = 1'b1;
                end else begin
                    abort_code = `TSOD_ABT_SIG;
                end
            end else begin
                if (REQ.data == `TSOD_SIG_LOAD) begin
                    nv_load = 1'b1;
                end else begin
                    abort_code = `TSOD_ABT_SIG;
                end
            end
        end else if (REQ.index == `TSOD_IDX_POS_LONG) begin
            rd_data = {16'h0000, tilt_long_ff};
            if (REQ.write) begin
                abort_code = `TSOD_ABT_RO;
            end
        end else if (REQ.index == `TSOD_IDX_POS_TRANS) begin
            rd_data = {16'h0000, tilt_trans_ff};
            if (REQ.write) begin
                abort_code = `TSOD_ABT_RO;
            end
        end else if (REQ.index == `TSOD_IDX_OP_LONG) begin
            rd_data = {24'h00_0000, op_long_ff};
            wr_op_long = REQ.write;
        end else if (REQ.index == `TSOD_IDX_OP_TRANS) begin
            rd_data = {24'h00_0000, op_trans_ff};
            wr_op_trans = REQ.write;
        end else if (REQ.index == `TSOD_IDX_OFS_LONG) begin
            rd_data = {16'h0000, ofs_long_ff};
            wr_ofs_long = REQ.write;
        end else if (REQ.index == `TSOD_IDX_OFS_TRANS) begin
            rd_data = {16'h0000, ofs_trans_ff};
            wr_ofs_trans = REQ.write;
        end else begin
            abort_code = `TSOD_ABT_NO_OBJ;
        end
        req_abort = (abort_code != 32'h0000_0000);
    end

    // Answer one cycle after every request
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.valid <= REQ.valid;
            rsp_ff.abort <= REQ.valid && req_abort;
            rsp_ff.data <= req_abort ? abort_code : rd_data;
        end
    end

    // Configuration objects
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            op_long_ff <= 8'h00;
            op_trans_ff <= 8'h00;
            ofs_long_ff <= 16'h0000;
            ofs_trans_ff <= 16'h0000;
            sync_id_ff <= `TSOD_SYNC_ID_RST;
            guard_ff <= 16'h0000;
            life_ff <= 8'h00;
        end else if (REQ.valid) begin
            if (wr_op_long) begin
                op_long_ff <= REQ.data[7:0];
            end
            if (wr_op_trans) begin
                op_trans_ff <= REQ.data[7:0];
            end
            if (wr_ofs_long) begin
                ofs_long_ff <= REQ.data[15:0];
            end
            if (wr_ofs_trans) begin
                ofs_trans_ff <= REQ.data[15:0];
            end
            if (wr_sync) begin
                sync_id_ff <= REQ.data;
            end
            if (wr_guard) begin
                guard_ff <= REQ.data[15:0];
            end
            if (wr_life) begin
                life_ff <= REQ.data[7:0];
            end
        end
    end

    // Position transform, each axis with its own selection
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tilt_long_ff <= 16'h0000;
            tilt_trans_ff <= 16'h0000;
        end else begin
            tilt_long_ff <= tilt_xform(POS_LONG, op_long_ff, ofs_long_ff);
            tilt_trans_ff <= tilt_xform(POS_TRANS, op_trans_ff,
                                        ofs_trans_ff);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            life_ms_ff <= 24'h00_0000;
        end else begin
            life_ms_ff <= 24'(life_ff) * 24'(guard_ff);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fault_flags_ff <= 8'h00;
        end else begin
            fault_flags_ff <= 8'h00;
            fault_flags_ff[`TSOD_FAULT_GENERIC_BIT] <= FAULT_ACTIVE;
        end
    end

    // Newest entry at slot 0; a new error beats a same-cycle clear
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            log_cnt_ff <= 8'h00;
            for (int i = 0; i < LOG_DEPTH; i++) begin
                log_ff[i] <= 32'h0000_0000;
            end
        end else if (FAULT_EVENT) begin
            log_ff[0] <= {FAULT_ENTRY.info, FAULT_ENTRY.code};
            for (int i = 1; i < LOG_DEPTH; i++) begin
                log_ff[i] <= log_ff[i-1];
            end
            if (REQ.valid && wr_log_clr) begin
                log_cnt_ff <= 8'h01;
            end else if (log_cnt_ff < LOG_MAX) begin
                log_cnt_ff <= 8'(log_cnt_ff + 8'h01);
            end
        end else if (REQ.valid && wr_log_clr) begin
            log_cnt_ff <= 8'h00;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pdo_send_ff <= 1'b0;
            pdo_data_ff <= 32'h0000_0000;
        end else begin
            pdo_send_ff <= SYNC_VALID && NMT_OPERATIONAL &&
                (SYNC_ID == sync_id_ff[`TSOD_SYNC_ID_W-1:0]);
            pdo_data_ff <= {tilt_trans_ff, tilt_long_ff};
        end
    end

    // Store/restore commands to the memory controller
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            nv_ff <= '0;
        end else begin
            nv_ff.store <= REQ.valid && nv_save;
            nv_ff.restore <= REQ.valid && nv_load;
            nv_ff.groups <= nv_groups;
            nv_ff.preset <= nv_groups[1];
            nv_ff.app_first <= 1'b1;
            nv_ff.keep_link <= 1'b1;
        end
    end

    // Defaults are only scheduled; the next power-up applies them
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            restore_pend_ff <= `TSOD_GRP_NONE;
        end else if (REQ.valid && nv_load) begin
            restore_pend_ff <= restore_pend_ff | nv_groups;
        end
    end

    assign RSP = rsp_ff;
    assign PDO_SEND = pdo_send_ff;
    assign PDO_DATA = pdo_data_ff;
    assign TILT_LONGITUDINAL_16BIT = tilt_long_ff;
    assign TILT_TRANSVERSE_16BIT = tilt_trans_ff;
    // Sign-extended copies; no decimal scaling
    assign TILT_LONGITUDINAL_32BIT = {{16{tilt_long_ff[15]}}, tilt_long_ff};
    assign TILT_TRANSVERSE_32BIT = {{16{tilt_trans_ff[15]}}, tilt_trans_ff};
    assign LIFE_TIME_MS = life_ms_ff;
    assign NV_CMD = nv_ff;
    assign NV_RESTORE_PENDING = restore_pend_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    invert_only_a: assert property (
        $past(op_long_ff) == 8'h01 |->
        tilt_long_ff == 16'(`TSOD_INV_BASE - {1'b0, $past(POS_LONG)}))
        else $error("inverted position wrong");
    scale_only_a: assert property (
        $past(op_long_ff) == 8'h02 |->
        tilt_long_ff == 16'($past(POS_LONG) + $past(ofs_long_ff)))
        else $error("scaled position wrong");
    invert_scale_a: assert property (
        $past(op_long_ff) == 8'h03 |->
        tilt_long_ff == 16'(16'(`TSOD_INV_BASE - {1'b0, $past(POS_LONG)})
                            + $past(ofs_long_ff)))
        else $error("inverted scaled position wrong");
    generic_fault_a: assert property (
        FAULT_ACTIVE |=> fault_flags_ff[`TSOD_FAULT_GENERIC_BIT])
        else $error("generic fault bit missing");
    log_clear_a: assert property (
        REQ.valid && wr_log_clr && !FAULT_EVENT |=> log_cnt_ff == 8'h00)
        else $error("log not cleared");
    sync_reply_a: assert property (
        SYNC_VALID && NMT_OPERATIONAL &&
        SYNC_ID == sync_id_ff[`TSOD_SYNC_ID_W-1:0] |=> PDO_SEND)
        else $error("sync reply missing");
    life_time_a: assert property (
        $stable(life_ff) && $stable(guard_ff) |->
        LIFE_TIME_MS == 24'(life_ff) * 24'(guard_ff))
        else $error("life time product wrong");
    save_commit_a: assert property (
        NV_CMD.store |-> $past(REQ.data) == `TSOD_SIG_SAVE &&
        $past(REQ.index) == `TSOD_IDX_STORE)
        else $error("store without signature");
    bad_sig_a: assert property (
        REQ.valid && REQ.write && REQ.index == `TSOD_IDX_STORE &&
        REQ.sub == `TSOD_SUB_ALL && REQ.data != `TSOD_SIG_SAVE
        |=> RSP.abort && !NV_CMD.store)
        else $error("bad signature accepted");
    restore_keep_a: assert property (
        NV_CMD.restore |-> NV_CMD.keep_link ##1 NV_RESTORE_PENDING != 3'b000)
        else $error("restore flags wrong");

    save_seen_c: cover property (NV_CMD.store);
    restore_seen_c: cover property (NV_CMD.restore);
    sync_seen_c: cover property (PDO_SEND);
    log_full_c: cover property (log_cnt_ff == LOG_MAX);

endmodule

/* File: sim/tsod_master_model.sv */
// Network master model: sends one dictionary request at a time.
// Assumes the block answers within three cycles of the taking edge.
`timescale 1ns/1ps
`include "tsod_defines.svh"
module tsod_master_model
    import tsod_pkg::*;
(
    input wire logic clk,
    output tsod_req_type req,
    input tsod_rsp_type rsp
);
    // Idle cycles before each request, so the bench can act slow
    int idle = 0;

    initial begin
        req = '0;
    end

    task automatic access(input logic wr, input logic [15:0] idx,
        input logic [7:0] sub, input logic [31:0] data,
        output tsod_rsp_type got, output logic ok);
        ok = 1'b0;
        got = '0;
        repeat (idle) @(posedge clk);
        @(posedge clk);
        #1;
        req = {1'b1, wr, idx, sub, data};
        @(posedge clk);
        #1;
        // Released lines show the inverse, so stale values never match
        req = {1'b0, ~wr, ~idx, ~sub, ~data};
        for (int n = 0; n < 4 && !ok; n++) begin
            if (rsp.valid === 1'b1) begin
                got = rsp;
                ok = 1'b1;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask

    // First letter rides in the lowest byte
    task automatic signature(input logic [15:0] idx, input logic [7:0] sub,
        input string word, output tsod_rsp_type got, output logic ok);
        logic [31:0] w;
        w = {word[3], word[2], word[1], word[0]};
        access(1'b1, idx, sub, w, got, ok);
    endtask

    // A zero count empties the whole log
    task automatic clear_log(output tsod_rsp_type got, output logic ok);
        access(1'b1, `TSOD_IDX_FAULT_HIST, `TSOD_SUB_ZERO, '0, got, ok);
    endtask
endmodule

/* File: sim/tsod_top_tb_top.sv */
// Bench: requests through the master model, checks answers, transform,
// fault log, sync reply, guarding figures and store/restore pulses.
// Assumes one clock; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`include "tsod_defines.svh"
module tsod_top_tb_top
    import tsod_pkg::*;
    ;
    localparam logic [15:0] PROF = 16'h0a5c; // Arbitrary value
    localparam logic [15:0] EXTRA = 16'h0031; // Arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    tsod_req_type req;
    tsod_rsp_type rsp;
    tsod_rsp_type r;
    tsod_fault_type f_entry;
    tsod_nv_type nv;
    logic ok, f_act, f_evt, nmt_op, s_valid, pdo_send;
    logic [10:0] s_id;
    logic [15:0] pos_l, pos_t, tl16, tt16, el, et;
    logic [31:0] tl32, tt32, pdo_data;
    logic [23:0] life;
    logic [2:0] pend, pend_e;
    logic [2:0] grp [4] = '{3'b111, 3'b001, 3'b010, 3'b100};
    int err_total = 0;
    int comparisons = 0;

    always #5 clk = ~clk;

    tsod_top #(.LOG_DEPTH(8), .DEV_PROFILE(PROF), .DEV_EXTRA(EXTRA))
        tsod_top_i (.CLK(clk), .RST_N(rst_n), .REQ(req), .RSP(rsp),
        .POS_LONG(pos_l), .POS_TRANS(pos_t), .FAULT_ACTIVE(f_act),
        .FAULT_EVENT(f_evt), .FAULT_ENTRY(f_entry),
        .NMT_OPERATIONAL(nmt_op), .SYNC_VALID(s_valid), .SYNC_ID(s_id),
        .PDO_SEND(pdo_send), .PDO_DATA(pdo_data),
        .TILT_LONGITUDINAL_16BIT(tl16), .TILT_TRANSVERSE_16BIT(tt16),
        .TILT_LONGITUDINAL_32BIT(tl32), .TILT_TRANSVERSE_32BIT(tt32),
        .LIFE_TIME_MS(life), .NV_CMD(nv), .NV_RESTORE_PENDING(pend));

    tsod_master_model tsod_master_model_i (.clk(clk), .req(req), .rsp(rsp));

    task automatic complete_run;
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Write answers carry no agreed data, so only reads and refusals
    task automatic answer(input logic wr, input logic abt,
        input logic [31:0] exp);
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] answer expected 1 seen 0");
            complete_run();
        end else begin
            chk("abort", abt, r.abort);
            if (abt || !wr) begin
                chk("data", exp, r.data);
            end
        end
    endtask

    task automatic ask(input logic wr, input logic [15:0] idx,
        input logic [7:0] sub, input logic [31:0] d, input logic abt,
        input logic [31:0] exp);
        tsod_master_model_i.access(wr, idx, sub, d, r, ok);
        answer(wr, abt, exp);
    endtask

    task automatic sig(input logic [15:0] idx, input logic [7:0] sub,
        input string w, input logic abt);
        tsod_master_model_i.signature(idx, sub, w, r, ok);
        answer(1'b1, abt, `TSOD_ABT_SIG);
    endtask

    task automatic sync(input logic [10:0] id, input logic exp);
        s_id = id;
        s_valid = 1'b1;
        tick(1);
        s_valid = 1'b0;
        s_id = ~id;
        chk("sync reply", exp, pdo_send);
        if (exp) begin
            chk("sync data", {et, el}, pdo_data);
        end
        tick(1);
        chk("sync reply end", 0, pdo_send);
    endtask

    initial begin
        pos_l = 16'h1043;
        pos_t = 16'h0200;
        f_act = 1'b0;
        f_evt = 1'b0;
        f_entry = '0;
        nmt_op = 1'b0;
        s_valid = 1'b0;
        s_id = '0;
        pend_e = '0;
        tick(5);
        rst_n = 1'b1;
        ask(0, `TSOD_IDX_DEV_TYPE, 0, 0, 0, {EXTRA, PROF});
        ask(1, `TSOD_IDX_DEV_TYPE, 0, 1, 1, `TSOD_ABT_RO);
        ask(0, `TSOD_IDX_SYNC_ID, 0, 0, 0, 32'h0000_0080);
        ask(0, `TSOD_IDX_GUARD, 0, 0, 0, 0);
        ask(0, `TSOD_IDX_LIFE, 0, 0, 0, 0);
        ask(0, `TSOD_IDX_FAULT_HIST, 0, 0, 0, 0);
        ask(0, `TSOD_IDX_STORE, 0, 0, 0, 4);
        ask(0, `TSOD_IDX_RESTORE, 0, 0, 0, 4);
        ask(0, `TSOD_IDX_STORE, 2, 0, 0, 1);
        ask(1, `TSOD_IDX_OFS_LONG, 0, 32'h00a8, 0, 0);
        ask(1, `TSOD_IDX_OFS_TRANS, 0, 32'h0011, 0, 0);
        for (int m = 0; m < 4; m++) begin
            el = m[0] ? 16'(17'h1_0000 - 17'(pos_l)) : pos_l;
            el = m[1] ? el + 16'h00a8 : el;
            ask(1, `TSOD_IDX_OP_LONG, 0, 32'(m), 0, 0);
            tick(2);
            chk("tilt long16", el, tl16);
            chk("tilt long32", {{16{el[15]}}, el}, tl32);
            chk("tilt trans16", pos_t, tt16);
        end
        et = 16'(17'h1_0000 - 17'(pos_t)) + 16'h0011;
        ask(1, `TSOD_IDX_OP_TRANS, 0, 3, 0, 0);
        tick(2);
        chk("tilt trans16", et, tt16);
        chk("tilt trans32", {{16{et[15]}}, et}, tt32);
        ask(0, `TSOD_IDX_POS_TRANS, 0, 0, 0, 32'(et));
        f_act = 1'b1;
        tick(2);
        ask(0, `TSOD_IDX_FAULT_FLAGS, 0, 0, 0, 1);
        f_act = 1'b0;
        tick(2);
        ask(0, `TSOD_IDX_FAULT_FLAGS, 0, 0, 0, 0);
        // Two events back to back, entry changes each cycle
        f_evt = 1'b1;
        for (int k = 0; k < 2; k++) begin
            f_entry = {16'h00c0 + 16'(k), 16'h5000 + 16'(k)};
            tick(1);
        end
        f_evt = 1'b0;
        ask(0, `TSOD_IDX_FAULT_HIST, 0, 0, 0, 2);
        ask(0, `TSOD_IDX_FAULT_HIST, 1, 0, 0, 32'h00c1_5001);
        ask(0, `TSOD_IDX_FAULT_HIST, 2, 0, 0, 32'h00c0_5000);
        ask(0, `TSOD_IDX_FAULT_HIST, 3, 0, 1, `TSOD_ABT_NO_SUB);
        ask(1, `TSOD_IDX_FAULT_HIST, 0, 5, 1, `TSOD_ABT_VALUE);
        tsod_master_model_i.clear_log(r, ok);
        answer(1'b1, 1'b0, 0);
        ask(0, `TSOD_IDX_FAULT_HIST, 0, 0, 0, 0);
        nmt_op = 1'b1;
        sync(11'h080, 1'b1);
        sync(11'h081, 1'b0);
        ask(1, `TSOD_IDX_SYNC_ID, 0, 32'h0000_0123, 0, 0);
        sync(11'h123, 1'b1);
        sync(11'h080, 1'b0);
        nmt_op = 1'b0;
        sync(11'h123, 1'b0);
        ask(1, `TSOD_IDX_GUARD, 0, 32'h1234, 0, 0);
        ask(1, `TSOD_IDX_LIFE, 0, 32'h0a, 0, 0);
        tick(2);
        chk("life time", 24'h1234 * 24'h0a, life);
        ask(0, `TSOD_IDX_LIFE, 0, 0, 0, 32'h0a);
        tsod_master_model_i.idle = 2;
        for (int s = 1; s <= 4; s++) begin
            sig(`TSOD_IDX_STORE, 8'(s), "save", 1'b0);
            chk("store pulse", 1, nv.store);
            chk("store groups", grp[s-1], nv.groups);
            chk("preset", grp[s-1][1], nv.preset);
            chk("app first", 1, nv.app_first);
            sig(`TSOD_IDX_RESTORE, 8'(s), "load", 1'b0);
            pend_e = pend_e | grp[s-1];
            chk("restore pulse", 1, nv.restore);
            chk("restore groups", grp[s-1], nv.groups);
            chk("keep link", 1, nv.keep_link);
            chk("pending", pend_e, pend);
        end
        ask(0, `TSOD_IDX_GUARD, 0, 0, 0, 32'h1234);
        sig(`TSOD_IDX_STORE, 1, "sav!", 1'b1);
        chk("no store", 0, nv.store);
        sig(`TSOD_IDX_RESTORE, 3, "save", 1'b1);
        chk("no restore", 0, nv.restore);
        ask(1, `TSOD_IDX_STORE, 5, `TSOD_SIG_SAVE, 1, `TSOD_ABT_NO_SUB);
        complete_run();
    end
endmodule
